// ### hw/pacc_pkg.sv
// Constants shared by the pulse accumulator design files.
// Assumes a 32-bit AXI4-Lite register bus with byte addresses decoded on the low bits.
package pacc_pkg;
  localparam int unsigned PACC_AW = 8;
  localparam logic [7:0] PACC_OFS_CTRL = 8'h00;
  localparam logic [7:0] PACC_OFS_COUNT = 8'h04;
  localparam logic [7:0] PACC_OFS_MASK = 8'h08;
  localparam logic [7:0] PACC_OFS_FLAGS = 8'h0C;
  // Control register field positions.
  localparam int unsigned PACC_CTRL_EN_BIT = 6;
  localparam int unsigned PACC_CTRL_MODE_BIT = 5;
  localparam int unsigned PACC_CTRL_EDGE_BIT = 4;
  localparam int unsigned PACC_CTRL_CCSEL_BIT = 2;
  // Mask and flag registers share these positions.
  localparam int unsigned PACC_OVF_BIT = 5;
  localparam int unsigned PACC_EDGE_BIT = 4;
  localparam logic [7:0] PACC_CTRL_RST = 8'h00;
  localparam logic [7:0] PACC_MASK_RST = 8'h00;
  localparam logic [7:0] PACC_FLAGS_RST = 8'h00;
  localparam logic [7:0] PACC_COUNT_MAX = 8'hFF;
  localparam int unsigned PACC_PRESC_DIV = 64;
  localparam int unsigned PACC_PRESC_W = 6;
  localparam logic [PACC_PRESC_W-1:0] PACC_PRESC_LAST = PACC_PRESC_W'(PACC_PRESC_DIV - 1);
  localparam logic [1:0] PACC_RESP_OKAY = 2'h0;
  localparam logic [1:0] PACC_RESP_SLVERR = 2'h2;
endpackage : pacc_pkg

// ### hw/pacc_edge_if.sv
// Carries the synchronised input level and its edge pulses between design modules.
// Assumes both ends run on the same clock.
`timescale 1ns/100ps
interface pacc_edge_if;
  logic level;
  logic rise;
  logic fall;
  modport src (output level, output rise, output fall);
  modport dst (input level, input rise, input fall);
endinterface : pacc_edge_if

// ### hw/pacc_edge_sync.sv
// Two-stage synchroniser and edge detector for the accumulator input pin.
// Assumes the pin is asynchronous to mclk_i and changes no faster than mclk_i / 2.
`timescale 1ns/100ps
module pacc_edge_sync (
  input wire logic mclk_i, // System clock.
  input wire logic rst_i, // Asynchronous reset, active high.
  input wire logic pin_i, // Raw accumulator input pin.
  pacc_edge_if.src edge_o // Synchronised level and edges.
);
  logic [2:0] sync_ff;

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      sync_ff <= 3'h0;
    end else begin
      sync_ff <= {sync_ff[1:0], pin_i};
    end
  end

  // Stage 0 is only read by stage 1; edges come from stages 1 and 2.
  assign edge_o.level = sync_ff[1];
  assign edge_o.rise = sync_ff[1] & ~sync_ff[2];
  assign edge_o.fall = ~sync_ff[1] & sync_ff[2];
endmodule : pacc_edge_sync

// ### hw/pacc_top.sv
// Pulse accumulator: 8-bit event counter or gated time accumulator with AXI4-Lite registers.
// Assumes a single 20 MHz clock and an external input pin asynchronous to it.
//
// What this block does
// - An 8-bit counter works as event counter or gated accumulator by mode bit.
// - Gated mode counts a free-running clock/64 tick while the input is active.
// - System enable 0 disables the accumulator, 1 enables it.
// - Mode bit 0 selects event counting, 1 selects gated accumulation.
// - Event mode counts falling edges if edge bit is 0, rising if 1.
// - Gated mode: low input inhibits if edge bit 0, high input if 1.
// - Capture/compare select: 0 enables compare five, 1 enables capture four.
// - Count register is readable and writable anytime and untouched by reset.
// - Count reads return the current value even while the gate is inactive.
// - Increments are synchronised so they never collide with register reads.
// - Overflow flag sets on wrap from max to zero; writing 1 to bit 5 clears.
// - Overflow enable requests an interrupt when flag is set; never alters flag.
// - Edge flag sets on each selected input edge while enabled; writing 1 to bit 4 clears.
// - Edge enable requests an interrupt when flag is set; never alters flag.
// - Each mask enable sits at the same bit position as its flag.
// - Unused low bits 3..0 of the flag register read zero.
`timescale 1ns/100ps
module pacc_top (
  input wire logic mclk_i, // System clock, 20 MHz.
  input wire logic rst_i, // Asynchronous reset, active high.
  input wire logic s_axi_awvalid, // Write address valid.
  output logic s_axi_awready, // Write address ready.
  input wire logic [7:0] s_axi_awaddr, // Write byte address.
  input wire logic s_axi_wvalid, // Write data valid.
  output logic s_axi_wready, // Write data ready.
  input wire logic [31:0] s_axi_wdata, // Write data.
  input wire logic [3:0] s_axi_wstrb, // Write byte strobes.
  output logic s_axi_bvalid, // Write response valid.
  input wire logic s_axi_bready, // Write response ready.
  output logic [1:0] s_axi_bresp, // Write response code.
  input wire logic s_axi_arvalid, // Read address valid.
  output logic s_axi_arready, // Read address ready.
  input wire logic [7:0] s_axi_araddr, // Read byte address.
  output logic s_axi_rvalid, // Read data valid.
  input wire logic s_axi_rready, // Read data ready.
  output logic [31:0] s_axi_rdata, // Read data.
  output logic [1:0] s_axi_rresp, // Read response code.
  input wire logic accum_input_pin_i, // External event or gate pin.
  output logic accum_ovf_irq_o, // Overflow interrupt request, level.
  output logic accum_edge_irq_o, // Input edge interrupt request, level.
  output logic capture_compare_sel_o // 0 compare five active, 1 capture four active.
);
  pacc_edge_if edge_bus ();

  // The synchroniser needs two clocks per input level to see every edge.
  pacc_edge_sync u_sync (
    .mclk_i (mclk_i),
    .rst_i (rst_i),
    .pin_i (accum_input_pin_i),
    .edge_o (edge_bus.src)
  );

  logic [7:0] ctrl_ff;
  logic [7:0] mask_ff;
  logic [7:0] count_ff;
  logic ovf_flag_ff;
  logic edge_flag_ff;
  logic [pacc_pkg::PACC_PRESC_W-1:0] presc_ff;
  logic aw_held_ff;
  logic w_held_ff;
  logic [7:0] aw_addr_ff;
  logic [7:0] w_byte_ff;
  logic w_lane_ff;
  logic bvalid_ff;
  logic [1:0] bresp_ff;
  logic rvalid_ff;
  logic [31:0] rdata_ff;
  logic [1:0] rresp_ff;
  logic count_known_ff;

  // Register bus handshakes.
  wire aw_take = s_axi_awvalid & s_axi_awready;
  wire w_take = s_axi_wvalid & s_axi_wready;
  wire ar_take = s_axi_arvalid & s_axi_arready;
  wire wr_fire = aw_held_ff & w_held_ff & ~bvalid_ff;

  assign s_axi_awready = ~aw_held_ff & ~bvalid_ff;
  assign s_axi_wready = ~w_held_ff & ~bvalid_ff;
  assign s_axi_arready = ~rvalid_ff;
  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp = bresp_ff;
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rdata = rdata_ff;
  assign s_axi_rresp = rresp_ff;

  // Write address decode.
  wire wr_ctrl = wr_fire & w_lane_ff & (aw_addr_ff == pacc_pkg::PACC_OFS_CTRL);
  wire wr_count = wr_fire & w_lane_ff & (aw_addr_ff == pacc_pkg::PACC_OFS_COUNT);
  wire wr_mask = wr_fire & w_lane_ff & (aw_addr_ff == pacc_pkg::PACC_OFS_MASK);
  wire wr_flags = wr_fire & w_lane_ff & (aw_addr_ff == pacc_pkg::PACC_OFS_FLAGS);
  wire wr_mapped = (aw_addr_ff == pacc_pkg::PACC_OFS_CTRL) |
                   (aw_addr_ff == pacc_pkg::PACC_OFS_COUNT) |
                   (aw_addr_ff == pacc_pkg::PACC_OFS_MASK) |
                   (aw_addr_ff == pacc_pkg::PACC_OFS_FLAGS);

  // Control fields.
  wire sys_en = ctrl_ff[pacc_pkg::PACC_CTRL_EN_BIT];
  wire gated_mode = ctrl_ff[pacc_pkg::PACC_CTRL_MODE_BIT];
  wire edge_ctrl = ctrl_ff[pacc_pkg::PACC_CTRL_EDGE_BIT];
  assign capture_compare_sel_o = ctrl_ff[pacc_pkg::PACC_CTRL_CCSEL_BIT];

  // Edge bit picks the counted edge; the same edge ends an active gate period.
  wire sel_edge = edge_ctrl ? edge_bus.rise : edge_bus.fall;
  wire gate_open = edge_bus.level ^ edge_ctrl;
  wire tick = (presc_ff == pacc_pkg::PACC_PRESC_LAST);
  wire mode_inc = gated_mode ? (tick & gate_open) : sel_edge;
  wire inc = sys_en & mode_inc;
  wire ovf_set = inc & ~wr_count & (count_ff == pacc_pkg::PACC_COUNT_MAX);
  wire edge_set = sys_en & sel_edge;

  // Write data wins over a coincident increment and never flags overflow.
  wire [7:0] nxt_count = wr_count ? w_byte_ff :
                         inc ? count_ff + 8'h01 : count_ff;
  // A hardware set in the clearing cycle wins over the clear.
  wire nxt_ovf = ovf_set | (ovf_flag_ff & ~(wr_flags & w_byte_ff[pacc_pkg::PACC_OVF_BIT]));
  wire nxt_edge = edge_set | (edge_flag_ff & ~(wr_flags & w_byte_ff[pacc_pkg::PACC_EDGE_BIT]));

  // Enables sit at the flag positions, so a plain AND gates each request.
  assign accum_ovf_irq_o = ovf_flag_ff & mask_ff[pacc_pkg::PACC_OVF_BIT];
  assign accum_edge_irq_o = edge_flag_ff & mask_ff[pacc_pkg::PACC_EDGE_BIT];

  // Read decode; the count is always visible, gate or no gate.
  wire rd_ctrl = (s_axi_araddr == pacc_pkg::PACC_OFS_CTRL);
  wire rd_count = (s_axi_araddr == pacc_pkg::PACC_OFS_COUNT);
  wire rd_mask = (s_axi_araddr == pacc_pkg::PACC_OFS_MASK);
  wire rd_flags = (s_axi_araddr == pacc_pkg::PACC_OFS_FLAGS);
  wire [7:0] flags_view = {2'h0, ovf_flag_ff, edge_flag_ff, 4'h0};
  wire [7:0] rd_byte = rd_ctrl ? ctrl_ff :
                       rd_count ? count_ff :
                       rd_mask ? mask_ff :
                       rd_flags ? flags_view : 8'h00;
  wire rd_mapped = rd_ctrl | rd_count | rd_mask | rd_flags;

  // Only the implemented control and mask bits are stored; others read zero.
  wire [7:0] ctrl_wmask = 8'h74;
  wire [7:0] mask_wmask = 8'h30;

  // Count has no reset: its contents survive a reset.
  // Updates land on the clock edge while reads sample settled data between edges.
  always_ff @(posedge mclk_i) begin
    count_ff <= nxt_count;
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      ctrl_ff <= pacc_pkg::PACC_CTRL_RST;
      mask_ff <= pacc_pkg::PACC_MASK_RST;
      ovf_flag_ff <= pacc_pkg::PACC_FLAGS_RST[pacc_pkg::PACC_OVF_BIT];
      edge_flag_ff <= pacc_pkg::PACC_FLAGS_RST[pacc_pkg::PACC_EDGE_BIT];
      presc_ff <= '0;
    end else begin
      if (wr_ctrl) begin
        ctrl_ff <= w_byte_ff & ctrl_wmask;
      end
      if (wr_mask) begin
        mask_ff <= w_byte_ff & mask_wmask;
      end
      ovf_flag_ff <= nxt_ovf;
      edge_flag_ff <= nxt_edge;
      presc_ff <= presc_ff + 1'b1;
    end
  end

  // Write channel: address and data are taken in either order, then answered.
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      aw_held_ff <= 1'b0;
      w_held_ff <= 1'b0;
      aw_addr_ff <= 8'h00;
      w_byte_ff <= 8'h00;
      w_lane_ff <= 1'b0;
      bvalid_ff <= 1'b0;
      bresp_ff <= pacc_pkg::PACC_RESP_OKAY;
    end else begin
      if (aw_take) begin
        aw_held_ff <= 1'b1;
        aw_addr_ff <= s_axi_awaddr;
      end
      if (w_take) begin
        w_held_ff <= 1'b1;
        w_byte_ff <= s_axi_wdata[7:0];
        w_lane_ff <= s_axi_wstrb[0];
      end
      if (wr_fire) begin
        aw_held_ff <= 1'b0;
        w_held_ff <= 1'b0;
        bvalid_ff <= 1'b1;
        bresp_ff <= wr_mapped ? pacc_pkg::PACC_RESP_OKAY : pacc_pkg::PACC_RESP_SLVERR;
      end else if (bvalid_ff & s_axi_bready) begin
        bvalid_ff <= 1'b0;
      end
    end
  end

  // Read channel: one cycle from address to data.
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      rvalid_ff <= 1'b0;
      rdata_ff <= 32'h0000_0000;
      rresp_ff <= pacc_pkg::PACC_RESP_OKAY;
    end else if (ar_take) begin
      rvalid_ff <= 1'b1;
      rdata_ff <= {24'h00_0000, rd_byte};
      rresp_ff <= rd_mapped ? pacc_pkg::PACC_RESP_OKAY : pacc_pkg::PACC_RESP_SLVERR;
    end else if (rvalid_ff & s_axi_rready) begin
      rvalid_ff <= 1'b0;
    end
  end

  // The count has no reset, so the disabled-hold check waits until software has written it once.
  // A reset clears this helper although the count survives, which only delays that check.
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      count_known_ff <= 1'b0;
    end else if (wr_count) begin
      count_known_ff <= 1'b1;
    end
  end

  default clocking dflt_cb @(posedge mclk_i);
  endclocking
  default disable iff (rst_i);

  event_count_a: assert property (
    (sys_en & ~gated_mode & sel_edge & ~wr_count) |=> (count_ff == $past(count_ff) + 8'h01))
    else $error("event edge did not advance the count");

  gate_inhibit_a: assert property (
    (gated_mode & ~gate_open & ~wr_count) |=> $stable(count_ff))
    else $error("count moved while gate inhibited");

  tick_period_a: assert property (
    tick |=> (~tick)[*8] ##1 (~tick)[*8] ##48 tick)
    else $error("prescale tick not every 64 clocks");

  disabled_hold_a: assert property (
    (count_known_ff & ~sys_en & ~wr_count) |=> $stable(count_ff))
    else $error("count moved while disabled");

  count_write_a: assert property (
    wr_count |=> (count_ff == $past(w_byte_ff)) && !(ovf_flag_ff && !$past(ovf_flag_ff)))
    else $error("count write lost or raised overflow");

  ovf_wrap_a: assert property (
    (inc & ~wr_count & (count_ff == pacc_pkg::PACC_COUNT_MAX)) |=>
      (ovf_flag_ff & (count_ff == 8'h00)))
    else $error("wrap did not set overflow");

  ovf_clear_a: assert property (
    (wr_flags & w_byte_ff[pacc_pkg::PACC_OVF_BIT] & ~ovf_set) |=> ~ovf_flag_ff)
    else $error("overflow flag not cleared by one");

  flag_zero_a: assert property (
    (wr_flags & ~w_byte_ff[pacc_pkg::PACC_EDGE_BIT] & edge_flag_ff) |=> edge_flag_ff)
    else $error("writing zero cleared edge flag");

  edge_flag_a: assert property (
    (sys_en & edge_bus.rise & edge_ctrl) |=> edge_flag_ff)
    else $error("selected edge did not set flag");

  ovf_irq_a: assert property (
    (ovf_set & mask_ff[pacc_pkg::PACC_OVF_BIT] & ~wr_mask) |=> accum_ovf_irq_o)
    else $error("overflow irq not requested");

  edge_irq_a: assert property (
    (edge_set & mask_ff[pacc_pkg::PACC_EDGE_BIT] & ~wr_mask) |=> accum_edge_irq_o)
    else $error("edge irq not requested");

  bresp_hold_a: assert property (
    (s_axi_bvalid & ~s_axi_bready) |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response changed before taken");

  low_bits_a: assert property (
    (ar_take & rd_flags) |=> (s_axi_rdata[3:0] == 4'h0) && s_axi_rvalid)
    else $error("flag register low bits not zero");

  rdata_hold_a: assert property (
    (s_axi_rvalid & ~s_axi_rready) |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data changed before taken");

  ovf_seen_c: cover property (ovf_set);
  gated_inc_c: cover property (gated_mode & inc);
  collide_c: cover property (inc & wr_count);
  edge_irq_c: cover property (accum_edge_irq_o);
  wrap_irq_c: cover property (ovf_set & mask_ff[pacc_pkg::PACC_OVF_BIT]);
endmodule : pacc_top

// ### sim/pacc_pin_model.sv
// Partner model: the external source that drives the accumulator input pin.
// Assumes the bench calls its tasks right after a rising clock edge.
`timescale 1ns/100ps
module pacc_pin_model (
  input wire logic mclk_i, // Bench clock.
  output logic pin_o // Drives the accumulator input.
);
  initial pin_o = 1'b0;
  // Every level is held three clocks or more, so the source never outruns the sampler.
  task automatic hold(input logic lvl, input int n);
    pin_o <= lvl;
    repeat (n) @(posedge mclk_i);
  endtask : hold
  // One pulse gives one rising and one falling edge.
  task automatic pulses(input int n);
    repeat (n) begin
      hold(1'b1, 3);
      hold(1'b0, 3);
    end
  endtask : pulses
endmodule : pacc_pin_model

// ### sim/pulse_accumulator_tb.sv
// Self-checking bench for the pulse accumulator top level.
// Assumes the design package and the pin partner model are compiled first.
`timescale 1ns/100ps
module pulse_accumulator_tb;
  logic mclk_i, rst_i, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [7:0] s_axi_awaddr, s_axi_araddr, v;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic accum_input_pin_i, accum_ovf_irq_o, accum_edge_irq_o, capture_compare_sel_o;
  int miscompares = 0;
  int check_count = 0;
  logic [33:0] exp_rd[$];
  logic [1:0] exp_wr[$];
  localparam logic [7:0] a_ctl = pacc_pkg::PACC_OFS_CTRL;
  localparam logic [7:0] a_cnt = pacc_pkg::PACC_OFS_COUNT;
  localparam logic [7:0] a_msk = pacc_pkg::PACC_OFS_MASK;
  localparam logic [7:0] a_flg = pacc_pkg::PACC_OFS_FLAGS;
  localparam logic [1:0] ok = pacc_pkg::PACC_RESP_OKAY;
  localparam logic [1:0] err = pacc_pkg::PACC_RESP_SLVERR;

  pacc_top dut (.mclk_i, .rst_i, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr, .s_axi_wvalid,
    .s_axi_wready, .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp,
    .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata,
    .s_axi_rresp, .accum_input_pin_i, .accum_ovf_irq_o, .accum_edge_irq_o,
    .capture_compare_sel_o);
  pacc_pin_model pm (.mclk_i(mclk_i), .pin_o(accum_input_pin_i));

  task automatic chk(input string what, input logic [33:0] exp, input logic [33:0] got);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic close_out();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : close_out

  // Address and data are offered together and each is released once taken.
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] r = ok);
    bit aw;
    bit w;
    aw = 1;
    w = 1;
    exp_wr.push_back(r);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h00_0000, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    while (aw || w) begin
      @(posedge mclk_i);
      if (aw && s_axi_awready) begin
        aw = 0;
        s_axi_awvalid <= 1'b0;
      end
      if (w && s_axi_wready) begin
        w = 0;
        s_axi_wvalid <= 1'b0;
      end
    end
    do @(posedge mclk_i); while (!s_axi_bvalid);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] d, input logic [1:0] r = ok);
    exp_rd.push_back({r, 24'h00_0000, d});
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge mclk_i); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge mclk_i); while (!s_axi_rvalid);
  endtask : rd

  // Level outputs are looked at once the write that set them has settled.
  task automatic outs(input logic [2:0] e);
    @(negedge mclk_i);
    chk("irq_ovf_edge_ccsel", {31'h0, e},
      {31'h0, accum_ovf_irq_o, accum_edge_irq_o, capture_compare_sel_o});
  endtask : outs

  // Responses are matched in order against what the driver noted.
  always @(posedge mclk_i) begin
    if (s_axi_rvalid && s_axi_rready) chk("read", exp_rd.pop_front(), {s_axi_rresp, s_axi_rdata});
    if (s_axi_bvalid && s_axi_bready) chk("bresp", {32'h0, exp_wr.pop_front()}, {32'h0, s_axi_bresp});
  end

  initial begin
    mclk_i = 1'b0;
    forever #25 mclk_i = ~mclk_i;
  end

  // The tests need under a thousand clocks; twenty thousand means a hang.
  initial begin
    #1_000_000;
    miscompares++;
    close_out();
  end

  initial begin
    rst_i = 1'b1;
    s_axi_awvalid = 1'b0;
    s_axi_wvalid = 1'b0;
    s_axi_arvalid = 1'b0;
    s_axi_awaddr = 8'h00;
    s_axi_araddr = 8'h00;
    s_axi_wdata = 32'h0000_0000;
    s_axi_wstrb = 4'hf;
    s_axi_bready = 1'b1;
    s_axi_rready = 1'b1;
    void'($urandom(32'h0000_052a));
    repeat (5) @(posedge mclk_i);
    rst_i <= 1'b0;
    rd(a_ctl, pacc_pkg::PACC_CTRL_RST);
    rd(a_msk, pacc_pkg::PACC_MASK_RST);
    rd(a_flg, pacc_pkg::PACC_FLAGS_RST);
    rd(8'h10, 8'h00, err);
    wr(8'h10, 8'hff, err);
    // Enable stays off here so an open gate cannot move the count under the read.
    repeat (4) begin
      v = 8'($urandom);
      wr(a_cnt, v);
      rd(a_cnt, v);
      wr(a_ctl, v & 8'hbf);
      rd(a_ctl, v & 8'h34);
      outs({2'h0, v[2]});
    end
    // Byte lane 0 off: the write is answered but changes nothing.
    s_axi_wstrb <= 4'he;
    wr(a_cnt, ~v);
    s_axi_wstrb <= 4'hf;
    rd(a_cnt, v);
    wr(a_ctl, 8'h40);
    wr(a_cnt, 8'hfe);
    pm.pulses(2);
    rd(a_cnt, 8'h00);
    rd(a_flg, 8'h30);
    wr(a_msk, 8'h30);
    rd(a_msk, 8'h30);
    outs(3'h6);
    wr(a_flg, 8'h00);
    rd(a_flg, 8'h30);
    wr(a_flg, 8'h20);
    rd(a_flg, 8'h10);
    outs(3'h2);
    wr(a_flg, 8'h10);
    rd(a_flg, 8'h00);
    outs(3'h0);
    wr(a_msk, 8'h00);
    pm.pulses(1);
    rd(a_flg, 8'h10);
    outs(3'h0);
    wr(a_flg, 8'h30);
    wr(a_ctl, 8'h50);
    wr(a_msk, 8'h30);
    wr(a_cnt, 8'hfe);
    pm.pulses(3);
    rd(a_cnt, 8'h01);
    outs(3'h6);
    wr(a_flg, 8'h30);
    wr(a_ctl, 8'h00);
    pm.pulses(2);
    rd(a_cnt, 8'h01);
    rd(a_flg, 8'h00);
    // A gate held open for exactly three prescaler periods holds exactly three ticks.
    wr(a_ctl, 8'h60);
    wr(a_cnt, 8'h00);
    pm.hold(1'b1, 3 * pacc_pkg::PACC_PRESC_DIV);
    pm.hold(1'b0, 10);
    rd(a_cnt, 8'h03);
    wr(a_ctl, 8'h00);
    pm.hold(1'b1, 3);
    wr(a_ctl, 8'h70);
    pm.hold(1'b1, 3 * pacc_pkg::PACC_PRESC_DIV);
    rd(a_cnt, 8'h03);
    // With the edge bit set a low level opens the gate for exactly three periods.
    pm.hold(1'b0, 3 * pacc_pkg::PACC_PRESC_DIV);
    pm.hold(1'b1, 10);
    rd(a_cnt, 8'h06);
    wr(a_ctl, 8'h00);
    pm.hold(1'b0, 3);
    close_out();
  end
endmodule : pulse_accumulator_tb
